// [rtl/soak_prog_pkg.sv]
// constants, field positions, reset values and types for the soak program and output select block
// assumes a 100 MHz core clock and 32-bit APB register access
package soak_prog_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_SEC_NS = 500_000_000;
    localparam int HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;
    localparam int HALVES_PER_MIN = 120;
    localparam int HALVES_PER_HOUR = 7200;

    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_SOAK = 8'h08;
    localparam logic [7:0] OFS_BAND = 8'h0c;
    localparam logic [7:0] OFS_SETPOINT = 8'h10;
    localparam logic [7:0] OFS_LIMIT = 8'h14;
    localparam logic [7:0] OFS_MANUAL = 8'h18;
    localparam logic [7:0] OFS_AT_STOP = 8'h1c;
    localparam logic [7:0] OFS_AT_ERROR = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_ELAPSED = 8'h28;

    localparam int CMD_START = 0;
    localparam int CMD_RESET = 1;
    localparam int CMD_RUN = 2;
    localparam int CMD_STOP = 3;

    localparam int CFG_PAT_LO = 0;
    localparam int CFG_PAT_HI = 1;
    localparam int CFG_UNIT_HOUR = 2;
    localparam int CFG_MANUAL = 3;
    localparam int CFG_HEAT_COOL = 4;
    localparam int CFG_MAN_LIMIT = 5;
    localparam int CFG_STOP_ADD = 6;
    localparam int CFG_EVT_START = 7;

    localparam logic [1:0] PAT_OFF = 2'h0;
    localparam logic [1:0] PAT_STOP = 2'h1;
    localparam logic [1:0] PAT_CONTINUE = 2'h2;

    localparam logic [13:0] SOAK_MIN = 14'h0001;
    localparam logic [13:0] SOAK_MAX = 14'h270f;
    localparam logic [15:0] RST_BAND = 16'h0000;
    localparam logic [15:0] RST_SETPOINT = 16'h0000;
    localparam logic [15:0] RST_LIM_HI = 16'h041a;
    localparam logic [15:0] RST_LIM_LO = 16'hffce;
    localparam logic [15:0] RST_AT_STOP = 16'h0000;
    localparam logic [15:0] RST_AT_ERROR = 16'h0000;
    localparam logic [15:0] DRV_STD_LO = 16'hffce;
    localparam logic [15:0] DRV_HC_LO = 16'hfbe6;
    localparam logic [15:0] DRV_HI = 16'h041a;

    typedef enum logic {PROG_RESET, PROG_STARTED} prog_state_t;

endpackage : soak_prog_pkg

// [rtl/soak_program_and_output_select.sv]
// soak program sequencer with run/stop forcing, plus output drive selection and limiting
// assumes synchronous inputs on CORE_CLK, an APB master, drive values signed in tenths of a percent
`timescale 1ns/1ps
module soak_program_and_output_select
    import soak_prog_pkg::*;
#(
    parameter int HALF_SEC_COUNT = HALF_SEC_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] MEASURED_PROCESS_VALUE,
    input wire logic INPUT_ERROR,
    input wire logic [15:0] CALC_DRIVE_LEVEL,
    input wire logic EVENT_START,
    output logic [15:0] OUTPUT_DRIVE_LEVEL,
    output logic [15:0] HEAT_DRIVE,
    output logic [15:0] COOL_DRIVE,
    output logic RUN,
    output logic PROGRAM_END,
    output logic END_BLINK
);

    if (HALF_SEC_COUNT < 2) begin : g_bad_count
        $error("HALF_SEC_COUNT must be at least 2");
    end
    // the halves counter is 13 bits wide, enough for the hour unit and no more
    if (HALVES_PER_HOUR > 8191 || HALVES_PER_MIN < 1) begin : g_bad_unit
        $error("unit length does not fit the halves counter");
    end
    if (SOAK_MIN == 14'h0000 || SOAK_MAX < SOAK_MIN) begin : g_bad_soak
        $error("soak range must start at one and not be empty");
    end
    // a crossed reset pair would make the clamp give one of the two limits for every input, never the input itself
    if ($signed(RST_LIM_LO) > $signed(RST_LIM_HI)) begin : g_bad_limits
        $error("reset limits are crossed");
    end

    typedef struct packed {
        prog_state_t prog;
        logic run;
        logic done;
        logic blink;
        logic evt_q1;
        logic evt_q2;
        logic [31:0] div;
        logic [12:0] halves;
        logic [13:0] elapsed;
        logic [1:0] pattern;
        logic unit_hour;
        logic manual;
        logic heat_cool;
        logic man_limit;
        logic stop_add;
        logic evt_start;
        logic [13:0] soak;
        logic [15:0] band;
        logic signed [15:0] setpoint;
        logic signed [15:0] lim_hi;
        logic signed [15:0] lim_lo;
        logic signed [15:0] drv_man;
        logic signed [15:0] drv_stop;
        logic signed [15:0] drv_err;
        logic signed [15:0] drv_out;
        logic [15:0] heat;
        logic [15:0] cool;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t s;
    state_t n;

    function automatic logic signed [15:0] clamp(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        logic signed [15:0] r;
        r = v;
        if (v > hi) begin
            r = hi;
        end
        if (v < lo) begin
            r = lo;
        end
        return r;
    endfunction : clamp

    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFS_CMD || a == OFS_CFG || a == OFS_SOAK || a == OFS_BAND ||
               a == OFS_SETPOINT || a == OFS_LIMIT || a == OFS_MANUAL ||
               a == OFS_AT_STOP || a == OFS_AT_ERROR || a == OFS_STATUS ||
               a == OFS_ELAPSED;
    endfunction : is_mapped

    // a command bit acts only at the edge where its write completes
    function automatic logic cmd_key(
        input logic w,
        input logic [7:0] a,
        input logic [31:0] d,
        input int pos
    );
        return w && a == OFS_CMD && d[pos];
    endfunction : cmd_key

    // at-stop and at-error share one accepted range, reaching further down in heating/cooling
    function automatic logic drive_ok(input logic signed [15:0] v, input logic hc);
        logic signed [15:0] lo;
        lo = hc ? $signed(DRV_HC_LO) : $signed(DRV_STD_LO);
        return v >= lo && v <= $signed(DRV_HI);
    endfunction : drive_ok

    // distance is one bit wider so opposite full-scale values cannot wrap
    function automatic logic within_band(
        input logic signed [15:0] sp,
        input logic signed [15:0] meas,
        input logic [15:0] band
    );
        logic signed [16:0] d;
        logic [16:0] m;
        d = {sp[15], sp} - {meas[15], meas};
        m = d[16] ? 17'(-d) : 17'(d);
        return band == 16'h0000 || m <= {1'b0, band};
    endfunction : within_band

    function automatic state_t reset_state();
        state_t r;
        r = '0;
        r.prog = PROG_RESET;
        r.pattern = PAT_OFF;
        r.soak = SOAK_MIN;
        r.band = RST_BAND;
        r.setpoint = RST_SETPOINT;
        r.lim_hi = RST_LIM_HI;
        r.lim_lo = RST_LIM_LO;
        r.drv_stop = RST_AT_STOP;
        r.drv_err = RST_AT_ERROR;
        return r;
    endfunction : reset_state

    logic acc;
    logic wr;
    logic key_start;
    logic key_reset;
    logic key_run;
    logic key_stop;
    logic ev_rise;
    logic ev_fall;
    logic start_req;
    logic reset_req;
    logic tick;
    logic answer;
    logic in_band;
    logic [12:0] unit_halves;
    logic [13:0] elapsed_inc;
    logic unit_done;
    logic soak_due;
    logic signed [15:0] wval;
    logic signed [15:0] calc_lim;
    logic signed [15:0] man_val;
    logic signed [15:0] sel;
    logic [31:0] rdata;

    always_comb begin
        n = s;
        acc = PSEL & PENABLE;
        wr = acc & s.pready & PWRITE;
        wval = $signed(PWDATA[15:0]);
        answer = acc & ~s.pready;
        rdata = 32'h0000_0000;
        unique case (PADDR)
            OFS_CFG: rdata = {24'h00_0000, s.evt_start, s.stop_add, s.man_limit, s.heat_cool,
                              s.manual, s.unit_hour, s.pattern};
            OFS_SOAK: rdata = {18'h0_0000, s.soak};
            OFS_BAND: rdata = {16'h0000, s.band};
            OFS_SETPOINT: rdata = {16'h0000, s.setpoint};
            OFS_LIMIT: rdata = {s.lim_lo, s.lim_hi};
            OFS_MANUAL: rdata = {16'h0000, s.drv_man};
            OFS_AT_STOP: rdata = {16'h0000, s.drv_stop};
            OFS_AT_ERROR: rdata = {16'h0000, s.drv_err};
            OFS_STATUS: rdata = {27'h000_0000, s.blink, in_band, s.done, s.run, s.prog == PROG_STARTED};
            OFS_ELAPSED: rdata = {18'h0_0000, s.elapsed};
            default: rdata = 32'h0000_0000;
        endcase
        // one wait state: answer in the second access cycle, data and error held with it
        n.pready = answer;
        n.pslverr = answer & ~is_mapped(PADDR);
        if (answer) begin
            n.prdata = rdata;
        end

        // event input owns program start and reset once assigned; start and reset keys are then ignored, run and stop keys still act
        n.evt_q1 = EVENT_START;
        n.evt_q2 = s.evt_q1;
        ev_rise = s.evt_start & s.evt_q1 & ~s.evt_q2;
        ev_fall = s.evt_start & ~s.evt_q1 & s.evt_q2;
        key_start = cmd_key(wr, PADDR, PWDATA, CMD_START) & ~s.evt_start;
        key_reset = cmd_key(wr, PADDR, PWDATA, CMD_RESET) & ~s.evt_start;
        key_run = cmd_key(wr, PADDR, PWDATA, CMD_RUN);
        key_stop = cmd_key(wr, PADDR, PWDATA, CMD_STOP);
        start_req = (key_start | ev_rise) & s.pattern != PAT_OFF & s.prog == PROG_RESET;
        reset_req = (key_reset | ev_fall | s.pattern == PAT_OFF) & s.prog == PROG_STARTED;

        if (wr) begin
            unique case (PADDR)
                OFS_CFG: begin
                    n.pattern = PWDATA[CFG_PAT_HI:CFG_PAT_LO] == 2'h3 ? s.pattern : PWDATA[CFG_PAT_HI:CFG_PAT_LO];
                    n.unit_hour = PWDATA[CFG_UNIT_HOUR];
                    n.manual = PWDATA[CFG_MANUAL];
                    n.heat_cool = PWDATA[CFG_HEAT_COOL];
                    n.man_limit = PWDATA[CFG_MAN_LIMIT];
                    n.stop_add = PWDATA[CFG_STOP_ADD];
                    n.evt_start = PWDATA[CFG_EVT_START];
                end
                OFS_SOAK: begin
                    if (PWDATA[13:0] >= SOAK_MIN && PWDATA[13:0] <= SOAK_MAX && PWDATA[31:14] == 18'h0_0000) begin
                        n.soak = PWDATA[13:0];
                    end
                end
                OFS_BAND: n.band = PWDATA[15:0];
                OFS_SETPOINT: n.setpoint = wval;
                OFS_LIMIT: begin
                    n.lim_hi = wval;
                    n.lim_lo = $signed(PWDATA[31:16]);
                end
                OFS_MANUAL: n.drv_man = wval;
                OFS_AT_STOP: begin
                    if (drive_ok(wval, s.heat_cool)) begin
                        n.drv_stop = wval;
                    end
                end
                OFS_AT_ERROR: begin
                    if (drive_ok(wval, s.heat_cool)) begin
                        n.drv_err = wval;
                    end
                end
                default: begin
                end
            endcase
        end

        // half-second time base; minutes and hours are counted in halves to stay under 32 bits
        tick = s.div == 32'(HALF_SEC_COUNT - 1);
        n.div = tick ? 32'h0000_0000 : s.div + 32'h0000_0001;

        in_band = within_band(s.setpoint, $signed(MEASURED_PROCESS_VALUE), s.band);
        unit_halves = s.unit_hour ? 13'(HALVES_PER_HOUR) : 13'(HALVES_PER_MIN);
        elapsed_inc = s.elapsed + 14'h0001;
        unit_done = s.halves + 13'h0001 >= unit_halves;
        soak_due = elapsed_inc >= s.soak;

        if (key_run) begin
            n.run = 1'b1;
        end
        if (key_stop) begin
            n.run = 1'b0;
        end

        // soak counts regardless of run/stop, only the band gates it
        if (s.prog == PROG_STARTED && !s.done && in_band && tick) begin
            if (unit_done) begin
                n.halves = 13'h0000;
                n.elapsed = elapsed_inc;
                if (soak_due) begin
                    n.done = 1'b1;
                    if (s.pattern == PAT_STOP) begin
                        n.run = 1'b0;
                    end
                end
            end else begin
                n.halves = s.halves + 13'h0001;
            end
        end

        if (s.done) begin
            n.blink = tick ? ~s.blink : s.blink;
        end

        // start and reset are applied last so they win over keys and completion in the same cycle, except that a reset after program end leaves run to the keys
        if (start_req) begin
            n.prog = PROG_STARTED;
            n.run = 1'b1;
            n.elapsed = 14'h0000;
            n.halves = 13'h0000;
            n.done = 1'b0;
            n.blink = 1'b0;
        end else if (reset_req) begin
            n.prog = PROG_RESET;
            if (!s.done) begin
                n.run = 1'b0;
            end
            n.done = 1'b0;
            n.blink = 1'b0;
        end

        calc_lim = clamp($signed(CALC_DRIVE_LEVEL), s.lim_lo, s.lim_hi);
        man_val = s.man_limit ? clamp(s.drv_man, s.lim_lo, s.lim_hi) : s.drv_man;
        // a stop or error value only acts once the addition setting is on; otherwise zero drive
        if (s.manual) begin
            sel = man_val;
        end else if (!s.run) begin
            sel = s.stop_add ? s.drv_stop : 16'sh0000;
        end else if (INPUT_ERROR) begin
            sel = s.stop_add ? s.drv_err : 16'sh0000;
        end else begin
            sel = calc_lim;
        end
        n.drv_out = sel;
        // standard control never drives the cooling side
        n.heat = 16'h0000;
        n.cool = 16'h0000;
        if (sel > 16'sh0000) begin
            n.heat = 16'(sel);
        end
        if (s.heat_cool && sel < 16'sh0000) begin
            n.cool = 16'(-sel);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s <= reset_state();
        end else begin
            s <= n;
        end
    end

    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign OUTPUT_DRIVE_LEVEL = s.drv_out;
    assign HEAT_DRIVE = s.heat;
    assign COOL_DRIVE = s.cool;
    assign RUN = s.run;
    assign PROGRAM_END = s.done;
    assign END_BLINK = s.blink;

endmodule : soak_program_and_output_select

// [verif/soak_prog_properties.sv]
// port checker for the soak program and output select block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module soak_prog_properties (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [15:0] OUTPUT_DRIVE_LEVEL,
    input wire logic [15:0] HEAT_DRIVE,
    input wire logic [15:0] COOL_DRIVE,
    input wire logic PROGRAM_END,
    input wire logic END_BLINK
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // exactly one wait state, so a stuck slave shows at once
    a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (PSEL && PENABLE && PREADY && PADDR > 8'h28 |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (PREADY && PADDR <= 8'h28 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("mapped access refused");
    a_blink_idle: assert property (!PROGRAM_END && !$past(PROGRAM_END) |-> !END_BLINK)
        else $error("end indication without program end");
    a_split_excl: assert property (HEAT_DRIVE != 16'h0 |-> COOL_DRIVE == 16'h0)
        else $error("heat and cool driven together");
    a_heat_part: assert property ($signed(OUTPUT_DRIVE_LEVEL) > 0 |-> HEAT_DRIVE == OUTPUT_DRIVE_LEVEL)
        else $error("positive drive not on heating side");
    a_cool_part: assert property (COOL_DRIVE != 16'h0 |-> COOL_DRIVE == 16'(-OUTPUT_DRIVE_LEVEL))
        else $error("cooling side not the negated drive");
endmodule : soak_prog_properties

bind soak_program_and_output_select soak_prog_properties u_props (.CORE_CLK(CORE_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OUTPUT_DRIVE_LEVEL(OUTPUT_DRIVE_LEVEL), .HEAT_DRIVE(HEAT_DRIVE), .COOL_DRIVE(COOL_DRIVE),
    .PROGRAM_END(PROGRAM_END), .END_BLINK(END_BLINK));

// [verif/plant_model.sv]
// process and event-input side: settles the process value and the event line
// assumes requests from the bench arrive on core clock edges
`timescale 1ns/1ps
module plant_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] meas_goal,
    input wire logic ev_go,
    output logic [15:0] meas,
    output logic ev
);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meas <= 16'h0;
            ev <= 1'b0;
        end else begin
            meas <= meas_goal; // settles in one clock, no overshoot modelled
            ev <= ev_go;
        end
    end
endmodule : plant_model

// [verif/soak_program_and_output_select_tb.sv]
// self-checking bench for the soak program and output select block
// assumes the plant model drives process value and event start
`timescale 1ns/1ps
module soak_program_and_output_select_tb;
    import soak_prog_pkg::*;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, in_err = 0, ev_go = 0, look = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ev, run, prog_end, blink;
    logic [15:0] meas, calc = 16'h0, meas_goal = 16'h0, drv, heat, cool;
    logic [31:0] rq[$];
    logic [33:0] oq[$];
    int n_mismatch = 0, n_checks = 0;
    always #5 core_clk = ~core_clk;
    plant_model u_plant (.core_clk(core_clk), .rst(rst), .meas_goal(meas_goal), .ev_go(ev_go), .meas(meas),
        .ev(ev));
    soak_program_and_output_select #(.HALF_SEC_COUNT(4)) dut_u (.CORE_CLK(core_clk), .RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MEASURED_PROCESS_VALUE(meas), .INPUT_ERROR(in_err),
        .CALC_DRIVE_LEVEL(calc), .EVENT_START(ev), .OUTPUT_DRIVE_LEVEL(drv), .HEAT_DRIVE(heat),
        .COOL_DRIVE(cool), .RUN(run), .PROGRAM_END(prog_end), .END_BLINK(blink));
    task cmp(input string nm, input logic [33:0] e, input logic [33:0] s);
        n_checks++;
        if (e !== s) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp
    // values seen before the edge's own updates land, so no race
    always @(posedge core_clk) begin
        if (pready === 1'b1 && pwrite === 1'b0) cmp("prdata", {2'b0, rq.pop_front()}, {2'b0, prdata});
        if (look === 1'b1) cmp("outputs", oq.pop_front(), {run, prog_end, drv, cool});
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for ready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task see(input logic r, input logic pe, input logic [15:0] d, input logic [15:0] c);
        repeat (4) @(posedge core_clk);
        oq.push_back({r, pe, d, c});
        look <= 1'b1;
        @(posedge core_clk);
        look <= 1'b0;
    endtask : see
    task wait_end;
        while (prog_end !== 1'b1) begin
            @(posedge core_clk);
        end
    endtask : wait_end
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // whole run is near 1800 cycles; over ten times that means a hang
    initial begin
        #250000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        int v, e;
        logic tog;
        void'($urandom(64));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(OFS_CFG, 32'h0);
        rd(OFS_SOAK, 32'h1);
        rd(OFS_LIMIT, {RST_LIM_LO, RST_LIM_HI});
        rd(8'h2c, 32'h0);
        see(1'b0, 1'b0, 16'h0, 16'h0);
        wr(OFS_CFG, 32'h50);
        wr(OFS_AT_STOP, 32'hfe70);
        see(1'b0, 1'b0, 16'hfe70, 16'h0190);
        wr(OFS_AT_STOP, 32'h041b);
        see(1'b0, 1'b0, 16'hfe70, 16'h0190);
        wr(OFS_AT_ERROR, 32'h012c);
        wr(OFS_CMD, 32'h4);
        in_err <= 1'b1;
        see(1'b1, 1'b0, 16'h012c, 16'h0);
        in_err <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 2000 : (i == 1) ? -300 : int'($urandom_range(1400)) - 200;
            e = (v > 1050) ? 1050 : (v < -50) ? -50 : v;
            calc <= 16'(v);
            see(1'b1, 1'b0, 16'(e), (e < 0) ? 16'(-e) : 16'h0);
        end
        wr(OFS_CFG, 32'h58);
        wr(OFS_MANUAL, 32'h07d0);
        see(1'b1, 1'b0, 16'h07d0, 16'h0);
        wr(OFS_CFG, 32'h78);
        wr(OFS_CMD, 32'h8);
        see(1'b0, 1'b0, 16'h041a, 16'h0);
        wr(OFS_CFG, 32'h50);
        in_err <= 1'b1;
        see(1'b0, 1'b0, 16'hfe70, 16'h0190);
        in_err <= 1'b0;
        calc <= 16'h0064;
        wr(OFS_CFG, 32'h01);
        wr(OFS_CMD, 32'h1);
        see(1'b1, 1'b0, 16'h0064, 16'h0);
        wr(OFS_CMD, 32'h2);
        see(1'b0, 1'b0, 16'h0, 16'h0);
        wr(OFS_CMD, 32'h1);
        wait_end();
        see(1'b0, 1'b1, 16'h0, 16'h0);
        tog = 1'b0;
        repeat (8) begin
            @(posedge core_clk);
            tog = tog | (blink === 1'b1);
        end
        cmp("end_blink", 34'h1, {33'h0, tog});
        wr(OFS_CMD, 32'h2);
        see(1'b0, 1'b0, 16'h0, 16'h0);
        wr(OFS_CMD, 32'h4);
        rd(OFS_STATUS, 32'h0a);
        wr(OFS_CMD, 32'h1);
        rd(OFS_STATUS, 32'h0b);
        wr(OFS_CMD, 32'h2);
        meas_goal <= 16'h01f4;
        wr(OFS_CFG, 32'h02);
        wr(OFS_BAND, 32'h0a);
        wr(OFS_CMD, 32'h1);
        repeat (600) @(posedge core_clk);
        rd(OFS_ELAPSED, 32'h0);
        wr(OFS_CMD, 32'h8);
        meas_goal <= 16'h0005;
        wait_end();
        see(1'b0, 1'b1, 16'h0, 16'h0);
        wr(OFS_CMD, 32'h2);
        wr(OFS_CFG, 32'h81);
        ev_go <= 1'b1;
        see(1'b1, 1'b0, 16'h0064, 16'h0);
        ev_go <= 1'b0;
        see(1'b0, 1'b0, 16'h0, 16'h0);
        wrap_up();
    end
endmodule : soak_program_and_output_select_tb
